// [rtl/vfs_regs.svh]
// Purpose: Constants for the video front end and vertical sync detector
// Assumes: 200 MHz mclk_in, 8-bit sample codes
// Notes:   Offsets, levels and counts as named macros
`ifndef VFS_REGS_SVH
`define VFS_REGS_SVH

`define VFS_REG_SYNC_LOCK_CONTROL   8'h04
`define VFS_LOST_FIELDS_BIT         2
`define VFS_CODE_WHITE              8'hC4
`define VFS_CODE_BLACK_M            8'h42
`define VFS_CODE_BLACK_BG           8'h3B
`define VFS_CODE_BLANK_M            8'h38
`define VFS_CODE_BLANK_BG           8'h3B
`define VFS_CODE_SYNC               8'h00
`define VFS_SYNC_SLICE              8'h1C
`define VFS_HALFBAND_TAPS           23
`define VFS_LOSS_LINES              5'h10
`define VFS_LOST_LINES              9'h151
`define VFS_LINE_LEN_M              11'h6B4
`define VFS_LINE_LEN_BG             11'h6C0
`define VFS_VSYNC_THRESH            11'h0C8
`define VFS_HSYNC_MAX               11'h080
`define VFS_NOSYNC_LINE             11'h7FF

`endif

// [rtl/vfs_pkg.sv]
// Purpose: Types for the video front end and vertical sync detector
// Assumes: Used with vfs_regs.svh
// Notes:   Input selection and PLL state encodings
package vfs_pkg;
	typedef enum logic [1:0] {
		VFS_SEL_COMP1 = 2'h0,
		VFS_SEL_COMP2 = 2'h1,
		VFS_SEL_COMP3 = 2'h2,
		VFS_SEL_SVIDEO = 2'h3
	} vfs_insel_e;
	typedef enum logic [1:0] {
		VFS_PLL_ACQUIRE = 2'h1,
		VFS_PLL_TRACK   = 2'h2
	} vfs_pll_e;
	typedef logic [7:0] vfs_sample_t;
endpackage

// [rtl/vfs_frontend.sv]
// Purpose: Video front end: input select, halfband filter, gain/clamp, vsync/field
// Assumes: Analog samples arrive already digitized once per sample_clock_en
// Notes:   Summary of rules follows
// Summary of operation
// - One of three composite inputs is decoded, picked by input select.
// - S-video takes luma from third composite input and chroma from chroma input.
// - Each converter channel has its own 23-tap halfband filter.
// - At 27MHz sampling the filter is flat to 5.4MHz, -3dB near 6.3MHz.
// - Coarse clamp on the selected luma input only, independent of PLL timing, puts sync tip in range.
// - One sample per sample clock, fed to the rate converter output.
// - White 196, sync 0, black 66 for M standards else 59.
// - Gain loop compares blank to 56 or 59 and steps gain.
// - Back porch level is low-pass filtered before measuring.
// - Restore loop offsets video so sync tip reads code 0.
// - Measuring windows follow the selected standard automatically; the code keeps the back porch window fixed at 0x0A0-0x0E0.
// - After 16 lines without signal, nominal timing is generated.
// - Signal loss raises a maskable event.
// - Low-time counter accumulates low time of every sync pulse.
// - Crossing the vertical threshold asserts vsync low and updates field same cycle.
// - Field output low for odd fields, high for even.
// - Vsync in first half of line is odd, second half even.
// - Without vsync the field output toggles once every 337 lines.
// - Vsync lost after 337 lines without vsync for 1 or 3 fields (bit 2).
// - Lost vsync returns both PLLs to acquisition.
// - A chroma PLL and a line-locked PLL hold lock.
`include "vfs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module vfs_frontend (
	// Clock and reset
	input  wire logic                mclk_in,
	input  wire logic                rst_in,
	input  wire logic                sample_clock_en_in,
	// Digitized inputs
	input  wire vfs_pkg::vfs_sample_t composite1_in,
	input  wire vfs_pkg::vfs_sample_t composite2_in,
	input  wire vfs_pkg::vfs_sample_t luma_or_third_composite_in,
	input  wire vfs_pkg::vfs_sample_t chroma_in,
	// Register port
	input  wire logic [7:0]          reg_addr_in,
	input  wire logic [7:0]          reg_wdata_in,
	input  wire logic                reg_wr_in,
	input  wire logic                reg_rd_in,
	output logic [7:0]               reg_rdata_out,
	// Mode controls
	input  wire vfs_pkg::vfs_insel_e input_select_in,
	input  wire logic                std_bg_in,
	input  wire logic                loss_mask_in,
	// Video and gain outputs
	output vfs_pkg::vfs_sample_t     luma_out,
	output vfs_pkg::vfs_sample_t     chroma_out,
	output logic                     sample_valid_out,
	output logic [7:0]               gain_out,
	output logic [7:0]               offset_out,
	output logic                     clamp_out,
	// Timing outputs
	output logic                     vsync_n_out,
	output logic                     field_out,
	output logic                     nominal_timing_out,
	output logic                     signal_loss_out,
	output logic                     loss_event_out,
	output logic                     vsync_lost_out,
	output vfs_pkg::vfs_pll_e        chroma_pll_state_out,
	output vfs_pkg::vfs_pll_e        line_pll_state_out
);
	import vfs_pkg::*;

	localparam int NTAP = `VFS_HALFBAND_TAPS;
	// Halfband taps, sum 64 for unity DC gain, every other tap zero beside centre
	localparam logic signed [7:0] COEF [NTAP] = '{
		8'shFF, 8'sh00, 8'sh01, 8'sh00, 8'shFE, 8'sh00, 8'sh04, 8'sh00,
		8'shF6, 8'sh00, 8'sh18, 8'sh20, 8'sh18, 8'sh00, 8'shF6, 8'sh00,
		8'sh04, 8'sh00, 8'shFE, 8'sh00, 8'sh01, 8'sh00, 8'shFF};

	logic [7:0] sync_ctrl_reg;
	vfs_sample_t sel_y, sel_c;
	vfs_sample_t tap_y [NTAP];
	vfs_sample_t tap_c [NTAP];
	logic signed [17:0] acc_y, acc_c;
	vfs_sample_t filt_y, filt_c, adj_y, porch_lp;
	logic [10:0] line_pos_reg, line_len, low_cnt_reg;
	logic [4:0]  loss_lines_reg;
	logic [8:0]  lines_since_reg;
	logic [1:0]  missed_fields_reg;
	logic        low_now, low_prev_reg, in_vsync_reg, sig_seen_reg;
	logic        thresh_hit, hsync_end;

	// Register port
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_ctrl_reg <= 8'h00;
		end else if (reg_wr_in && reg_addr_in == `VFS_REG_SYNC_LOCK_CONTROL) begin
			sync_ctrl_reg <= reg_wdata_in;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= (reg_addr_in == `VFS_REG_SYNC_LOCK_CONTROL) ? sync_ctrl_reg : 8'h00;
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	// Input selection
	always_comb begin
		sel_c = 8'h80;
		case (input_select_in)
			VFS_SEL_COMP1: sel_y = composite1_in;
			VFS_SEL_COMP2: sel_y = composite2_in;
			VFS_SEL_COMP3: sel_y = luma_or_third_composite_in;
			VFS_SEL_SVIDEO: begin
				sel_y = luma_or_third_composite_in;
				sel_c = chroma_in;
			end
			default: sel_y = composite1_in;
		endcase
	end

	// Delay lines, one per converter channel
	genvar gi;
	generate
		for (gi = 0; gi < NTAP; gi++) begin : g_tap
			always_ff @(posedge mclk_in or posedge rst_in) begin
				if (rst_in) begin
					tap_y[gi] <= 8'h00;
					tap_c[gi] <= 8'h80;
				end else if (sample_clock_en_in) begin
					tap_y[gi] <= (gi == 0) ? sel_y : tap_y[(gi == 0) ? 0 : gi - 1];
					tap_c[gi] <= (gi == 0) ? sel_c : tap_c[(gi == 0) ? 0 : gi - 1];
				end
			end
		end
	endgenerate

	// Symmetric halfband sum, flat to 5.4MHz at 27MHz
	always_comb begin
		acc_y = 18'sh00000;
		acc_c = 18'sh00000;
		for (int k = 0; k < NTAP; k++) begin
			acc_y = acc_y + COEF[k] * $signed({10'h000, tap_y[k]});
			acc_c = acc_c + COEF[k] * $signed({10'h000, tap_c[k]});
		end
	end

	always_comb begin
		filt_y = acc_y[17] ? 8'h00 : (|acc_y[16:14] ? 8'hFF : acc_y[13:6]);
		filt_c = acc_c[17] ? 8'h00 : (|acc_c[16:14] ? 8'hFF : acc_c[13:6]);
	end

	// Gain and offset applied after filtering; clamps sync at 0
	always_comb begin
		logic [15:0] prod;
		logic [8:0]  shifted;
		prod = {8'h00, filt_y} * {8'h00, gain_out};
		shifted = {1'b0, prod[13:6]} + {1'b0, offset_out};
		adj_y = (shifted < 9'h080) ? 8'h00 : ((shifted > 9'h17F) ? 8'hFF : shifted[7:0] - 8'h80);
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			luma_out <= 8'h00;
			chroma_out <= 8'h80;
			sample_valid_out <= 1'b0;
		end else begin
			sample_valid_out <= sample_clock_en_in;
			if (sample_clock_en_in) begin
				luma_out <= adj_y;
				chroma_out <= filt_c;
			end
		end
	end

	// Coarse clamp: pulls input up whenever raw level bottoms out
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			clamp_out <= 1'b0;
		end else if (sample_clock_en_in) begin
			clamp_out <= (sel_y == 8'h00);
		end
	end

	// Standard-dependent line length; the back porch window is fixed
	assign line_len = std_bg_in ? `VFS_LINE_LEN_BG : `VFS_LINE_LEN_M;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			line_pos_reg <= 11'h000;
		end else if (hsync_end) begin
			line_pos_reg <= 11'h000;
		end else if (sample_clock_en_in) begin
			if (line_pos_reg >= line_len - 11'h001) begin
				line_pos_reg <= 11'h000;
			end else begin
				line_pos_reg <= line_pos_reg + 11'h001;
			end
		end
	end

	// Back porch low-pass, then gain and restore loops
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			porch_lp <= 8'h00;
			gain_out <= 8'h40;
			offset_out <= 8'h80;
		end else if (sample_clock_en_in) begin
			if (line_pos_reg > 11'h0A0 && line_pos_reg < 11'h0E0) begin
				porch_lp <= porch_lp - (porch_lp >> 3) + (adj_y >> 3);
			end
			if (line_pos_reg == 11'h0E0) begin
				if (porch_lp < (std_bg_in ? `VFS_CODE_BLANK_BG : `VFS_CODE_BLANK_M) && gain_out != 8'hFF) begin
					gain_out <= gain_out + 8'h01;
				end else if (porch_lp > (std_bg_in ? `VFS_CODE_BLANK_BG : `VFS_CODE_BLANK_M) && gain_out != 8'h00) begin
					gain_out <= gain_out - 8'h01;
				end
			end
			// Sync tip lies just before the hsync-aligned line start
			if (line_pos_reg == line_len - 11'h020) begin
				if (adj_y > `VFS_CODE_SYNC && offset_out != 8'h00) begin
					offset_out <= offset_out - 8'h01;
				end else if (adj_y == `VFS_CODE_SYNC && offset_out != 8'hFF && sel_y != 8'h00) begin
					offset_out <= offset_out + 8'h01;
				end
			end
		end
	end

	// Low-time counter
	assign low_now = luma_out < `VFS_SYNC_SLICE;
	assign thresh_hit = low_now && low_cnt_reg == `VFS_VSYNC_THRESH - 11'h001 && sample_valid_out;
	assign hsync_end = !low_now && low_prev_reg && low_cnt_reg <= `VFS_HSYNC_MAX && low_cnt_reg != 11'h000
		&& sample_valid_out;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			low_cnt_reg <= 11'h000;
			low_prev_reg <= 1'b0;
		end else if (sample_valid_out) begin
			low_prev_reg <= low_now;
			if (low_now && low_cnt_reg != 11'h7FF) begin
				low_cnt_reg <= low_cnt_reg + 11'h001;
			end else if (!low_now) begin
				low_cnt_reg <= 11'h000;
			end
		end
	end

	// Vsync, field and lost-sync tracking
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			vsync_n_out <= 1'b1;
			in_vsync_reg <= 1'b0;
			field_out <= 1'b0;
			lines_since_reg <= 9'h000;
			missed_fields_reg <= 2'h0;
			vsync_lost_out <= 1'b0;
		end else begin
			if (thresh_hit && !in_vsync_reg) begin
				vsync_n_out <= 1'b0;
				in_vsync_reg <= 1'b1;
				field_out <= (line_pos_reg >= (line_len >> 1));
				lines_since_reg <= 9'h000;
				missed_fields_reg <= 2'h0;
				vsync_lost_out <= 1'b0;
			end else begin
				if (hsync_end && sample_valid_out) begin
					vsync_n_out <= 1'b1;
					in_vsync_reg <= 1'b0;
				end
				if (sample_clock_en_in && line_pos_reg == 11'h000) begin
					if (lines_since_reg == `VFS_LOST_LINES - 9'h001) begin
						lines_since_reg <= 9'h000;
						field_out <= ~field_out;
						if (missed_fields_reg == (sync_ctrl_reg[`VFS_LOST_FIELDS_BIT] ? 2'h2 : 2'h0)) begin
							vsync_lost_out <= 1'b1;
							missed_fields_reg <= 2'h0;
						end else begin
							missed_fields_reg <= missed_fields_reg + 2'h1;
						end
					end else begin
						lines_since_reg <= lines_since_reg + 9'h001;
					end
				end
			end
		end
	end

	// Signal loss over 16 lines
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			loss_lines_reg <= 5'h00;
			sig_seen_reg <= 1'b0;
			signal_loss_out <= 1'b0;
			loss_event_out <= 1'b0;
		end else begin
			loss_event_out <= 1'b0;
			if (sample_clock_en_in) begin
				if (line_pos_reg == 11'h000) begin
					sig_seen_reg <= 1'b0;
					if (sig_seen_reg) begin
						loss_lines_reg <= 5'h00;
						signal_loss_out <= 1'b0;
					end else if (loss_lines_reg == `VFS_LOSS_LINES - 5'h01) begin
						if (!signal_loss_out) begin
							loss_event_out <= !loss_mask_in;
						end
						signal_loss_out <= 1'b1;
					end else begin
						loss_lines_reg <= loss_lines_reg + 5'h01;
					end
				end
			end
			// Hsync seen wins over the line-start clear
			if (hsync_end) begin
				sig_seen_reg <= 1'b1;
			end
		end
	end

	assign nominal_timing_out = signal_loss_out;

	// Chroma and line PLL states
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			chroma_pll_state_out <= VFS_PLL_ACQUIRE;
			line_pll_state_out <= VFS_PLL_ACQUIRE;
		end else if (vsync_lost_out) begin
			chroma_pll_state_out <= VFS_PLL_ACQUIRE;
			line_pll_state_out <= VFS_PLL_ACQUIRE;
		end else if (thresh_hit) begin
			chroma_pll_state_out <= VFS_PLL_TRACK;
			line_pll_state_out <= VFS_PLL_TRACK;
		end
	end

	a_vsync_field_same: assert property (@(posedge mclk_in) disable iff (rst_in)
		(thresh_hit && !in_vsync_reg) |=> (!vsync_n_out && field_out == $past(line_pos_reg >= (line_len >> 1))))
		else $error("vsync or field not updated on threshold");
	a_vsync_release: assert property (@(posedge mclk_in) disable iff (rst_in)
		(hsync_end && sample_valid_out && !(thresh_hit && !in_vsync_reg)) |=> vsync_n_out)
		else $error("vsync not released after normal hsync");
	a_pll_acquire: assert property (@(posedge mclk_in) disable iff (rst_in)
		vsync_lost_out |=> (chroma_pll_state_out == VFS_PLL_ACQUIRE && line_pll_state_out == VFS_PLL_ACQUIRE))
		else $error("PLLs not in acquisition after lost sync");
	a_loss_event_mask: assert property (@(posedge mclk_in) disable iff (rst_in)
		loss_event_out |-> ($past(!loss_mask_in) && signal_loss_out))
		else $error("loss event while masked");
	a_nominal_timing: assert property (@(posedge mclk_in) disable iff (rst_in)
		(nominal_timing_out && sample_clock_en_in && !hsync_end && line_pos_reg == line_len - 11'h001)
		|=> line_pos_reg == 11'h000)
		else $error("nominal line timing not kept");
	a_sel_svideo: assert property (@(posedge mclk_in) disable iff (rst_in)
		(input_select_in == VFS_SEL_SVIDEO) |-> (sel_y == luma_or_third_composite_in && sel_c == chroma_in))
		else $error("S-video routing wrong");
	a_sel_comp: assert property (@(posedge mclk_in) disable iff (rst_in)
		(input_select_in == VFS_SEL_COMP2) |-> sel_y == composite2_in)
		else $error("composite routing wrong");
	a_low_count: assert property (@(posedge mclk_in) disable iff (rst_in)
		(sample_valid_out && low_now && low_cnt_reg < 11'h7FF) |=> low_cnt_reg == $past(low_cnt_reg) + 11'h001)
		else $error("low time not accumulated");
	a_field_toggle: assert property (@(posedge mclk_in) disable iff (rst_in)
		(sample_clock_en_in && line_pos_reg == 11'h000 && lines_since_reg == `VFS_LOST_LINES - 9'h001
		 && !(thresh_hit && !in_vsync_reg)) |=> field_out != $past(field_out))
		else $error("field did not toggle without vsync");

	c_vsync: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(vsync_n_out));
	c_loss: cover property (@(posedge mclk_in) disable iff (rst_in) loss_event_out);
	c_lost: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(vsync_lost_out));
endmodule // vfs_frontend

`default_nettype wire

// [verification/vfs_video_src.sv]
// Purpose: Source model feeding digitized composite samples
// Assumes: One sample every SAMPLE_DIV mclk cycles, M-standard line length
// Notes:   Off-enable cycles show inverted data on the active input
`include "vfs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module vfs_video_src #(
	parameter int SAMPLE_DIV = 2,
	parameter int LINE_LEN   = 1716,
	parameter int HS_LEN     = 64,
	parameter int VLOW_LEN   = 250
) (
	// Clock and reset
	input  wire logic            mclk_in,
	input  wire logic            rst_in,
	// Shape controls
	input  wire logic            hsync_on_in,
	input  wire logic            vlow_on_in,
	input  wire logic [10:0]     vlow_start_in,
	input  wire logic [7:0]      noise_in,
	// Samples
	output logic                 sample_en_out,
	output vfs_pkg::vfs_sample_t comp1_out,
	output vfs_pkg::vfs_sample_t comp2_out,
	output vfs_pkg::vfs_sample_t comp3_out,
	output vfs_pkg::vfs_sample_t chroma_out,
	// Position
	output logic [10:0]          pos_out,
	output logic [15:0]          line_out
);
	import vfs_pkg::*;
	int   div_reg;
	logic low;

	assign low = (hsync_on_in && pos_out < HS_LEN) ||
		(vlow_on_in && pos_out >= vlow_start_in && pos_out < vlow_start_in + VLOW_LEN);

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			div_reg <= 0;
			sample_en_out <= 1'b0;
			pos_out <= 11'h000;
			line_out <= 16'h0000;
			comp1_out <= `VFS_CODE_BLANK_M;
			comp2_out <= 8'h00;
			comp3_out <= 8'h00;
			chroma_out <= 8'h00;
		end else begin
			div_reg <= (div_reg == SAMPLE_DIV - 1) ? 0 : div_reg + 1;
			// Sample cadence, divided down from mclk_in by SAMPLE_DIV
			sample_en_out <= (div_reg == 0);
			if (div_reg == 0) begin
				comp1_out <= low ? `VFS_CODE_SYNC : `VFS_CODE_BLANK_M + {5'h00, noise_in[2:0]};
				pos_out <= (pos_out == LINE_LEN - 1) ? 11'h000 : pos_out + 11'h001;
				if (pos_out == LINE_LEN - 1) begin
					line_out <= line_out + 16'h0001;
				end
			end else begin
				comp1_out <= ~comp1_out;
			end
			comp2_out <= noise_in;
			comp3_out <= ~noise_in;
			chroma_out <= noise_in ^ 8'h5A;
		end
	end
endmodule // vfs_video_src

`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the video front end
// Assumes: Composite input 1 selected, M-standard timing
// Notes:   Random noise on unselected inputs and blank level
`include "vfs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
	import vfs_pkg::*;
	logic                 mclk_in;
	logic                 rst_in;
	logic [7:0]           reg_addr;
	logic [7:0]           reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [7:0]           reg_rdata_out;
	vfs_insel_e           input_select;
	logic                 std_bg;
	logic                 loss_mask;
	logic                 hsync_on;
	logic                 vlow_on;
	logic [10:0]          vlow_start;
	logic [7:0]           noise;
	logic                 src_en;
	vfs_sample_t          src_c1;
	vfs_sample_t          src_c2;
	vfs_sample_t          src_c3;
	vfs_sample_t          src_cr;
	logic [10:0]          src_pos;
	logic [15:0]          src_line;
	logic                 sample_valid_out;
	vfs_sample_t          luma_out;
	vfs_sample_t          chroma_out;
	logic                 clamp_out;
	logic [7:0]           gain_out;
	logic [7:0]           offset_out;
	logic                 vsync_n_out;
	logic                 field_out;
	logic                 nominal_timing_out;
	logic                 signal_loss_out;
	logic                 loss_event_out;
	logic                 vsync_lost_out;
	vfs_pll_e             chroma_pll_state_out;
	vfs_pll_e             line_pll_state_out;
	logic                 en_d;
	logic [7:0]           rd;
	logic [7:0]           wd;
	logic [7:0]           ua;
	logic [15:0]          l0;
	int                   errors;
	int                   n_tests;
	int                   cyc;
	int                   loss_events;
	int                   seed;

	vfs_video_src i_src (.mclk_in(mclk_in), .rst_in(rst_in), .hsync_on_in(hsync_on), .vlow_on_in(vlow_on),
		.vlow_start_in(vlow_start), .noise_in(noise), .sample_en_out(src_en), .comp1_out(src_c1),
		.comp2_out(src_c2), .comp3_out(src_c3), .chroma_out(src_cr), .pos_out(src_pos), .line_out(src_line));

	vfs_frontend i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .sample_clock_en_in(src_en),
		.composite1_in(src_c1), .composite2_in(src_c2), .luma_or_third_composite_in(src_c3),
		.chroma_in(src_cr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata_out), .input_select_in(input_select),
		.std_bg_in(std_bg), .loss_mask_in(loss_mask), .luma_out(luma_out), .chroma_out(chroma_out),
		.sample_valid_out(sample_valid_out), .gain_out(gain_out), .offset_out(offset_out),
		.clamp_out(clamp_out),
		.vsync_n_out(vsync_n_out), .field_out(field_out), .nominal_timing_out(nominal_timing_out),
		.signal_loss_out(signal_loss_out), .loss_event_out(loss_event_out), .vsync_lost_out(vsync_lost_out),
		.chroma_pll_state_out(chroma_pll_state_out), .line_pll_state_out(line_pll_state_out));

	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end

	task final_report();
		$display("Checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge mclk_in) begin
		noise <= 8'($random(seed));
		en_d <= src_en;
		cyc <= cyc + 1;
		if (loss_event_out === 1'b1) begin
			loss_events <= loss_events + 1;
		end
		if (cyc == 100000) begin
			errors = errors + 1;
			final_report();
		end
	end

	task chk_bit(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask

	task chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk_in);
		reg_wr <= 1'b0;
	endtask

	task reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk_in);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask

	task wait_pos(input logic [10:0] p);
		do @(posedge mclk_in); while (src_pos !== p);
	endtask

	task wait_line(input logic [15:0] n);
		while (src_line < n) @(posedge mclk_in);
	endtask

	// Long low run at a line offset, then check vsync, field and release
	task vsync_run(input logic [10:0] start, input logic exp_field);
		wait_pos(11'h000);
		vlow_start <= start;
		vlow_on <= 1'b1;
		wait_pos(start + 11'h080);
		#1;
		chk_byte("luma_sync", `VFS_CODE_SYNC, luma_out);
		chk_bit("clamp_low", 1'b1, clamp_out);
		wait_pos(start + 11'h0FC);
		#1;
		chk_bit("vsync_n_low", 1'b0, vsync_n_out);
		chk_bit("field", exp_field, field_out);
		vlow_on <= 1'b0;
		wait_pos(11'h000);
		wait_pos(11'h100);
		#1;
		chk_bit("vsync_n_release", 1'b1, vsync_n_out);
		chk_bit("clamp_blank", 1'b0, clamp_out);
		chk_byte("chroma_idle", 8'h80, chroma_out);
	endtask

	initial begin
		seed = 32'h2835;
		errors = 0;
		n_tests = 0;
		cyc = 0;
		loss_events = 0;
		rst_in = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		input_select = VFS_SEL_COMP1;
		std_bg = 1'b0;
		loss_mask = 1'b0;
		hsync_on = 1'b1;
		vlow_on = 1'b0;
		vlow_start = 11'h064;
		noise = 8'h00;
		repeat (12) @(posedge mclk_in);
		#1;
		chk_byte("gain", 8'h40, gain_out);
		chk_byte("offset", 8'h80, offset_out);
		chk_bit("vsync_n", 1'b1, vsync_n_out);
		chk_bit("field", 1'b0, field_out);
		chk_bit("vsync_lost", 1'b0, vsync_lost_out);
		chk_byte("chroma_pll", {6'h00, VFS_PLL_ACQUIRE}, {6'h00, chroma_pll_state_out});
		chk_byte("line_pll", {6'h00, VFS_PLL_ACQUIRE}, {6'h00, line_pll_state_out});
		@(posedge mclk_in);
		rst_in <= 1'b0;
		wd = 8'($random(seed));
		for (int i = 0; i < 3; i++) begin
			reg_write(`VFS_REG_SYNC_LOCK_CONTROL, wd);
			reg_read(`VFS_REG_SYNC_LOCK_CONTROL, rd);
			chk_byte("sync_lock_bit", wd & 8'h04, rd & 8'h04);
			wd = ~wd;
		end
		ua = 8'($random(seed));
		if (ua == `VFS_REG_SYNC_LOCK_CONTROL) begin
			ua = 8'h05;
		end
		reg_read(ua, rd);
		chk_byte("unmapped", 8'h00, rd);
		@(posedge mclk_in);
		#1;
		chk_byte("rdata_idle", 8'h00, reg_rdata_out);
		repeat (16) begin
			@(posedge mclk_in);
			#1;
			chk_bit("sample_valid", en_d, sample_valid_out);
		end
		wait_line(16'h0001);
		vsync_run(11'h064, 1'b0);
		vsync_run(11'h3E8, 1'b1);
		hsync_on <= 1'b0;
		l0 = src_line;
		wait_line(l0 + 16'h000F);
		#1;
		chk_bit("signal_loss_early", 1'b0, signal_loss_out);
		wait_line(l0 + 16'h0012);
		#1;
		chk_bit("signal_loss", 1'b1, signal_loss_out);
		chk_bit("nominal_timing", 1'b1, nominal_timing_out);
		chk_byte("loss_events", 8'h01, 8'(loss_events));
		chk_bit("vsync_lost_quiet", 1'b0, vsync_lost_out);
		// Walk every input selection; the routing assertions check only the COMP2 and S-video ones
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk_in);
			input_select <= vfs_insel_e'(2'(i));
		end
		repeat (2) @(posedge mclk_in);
		final_report();
	end
endmodule // tb

`default_nettype wire
